// ### host_terminal.sv
// host terminal model: drives the receive line and samples the transmit line
`timescale 1ns/1ps

module host_terminal
(
  input wire logic core_clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  initial
  begin
    rxd_out = 1'b1;
  end

  // start, payload lsb first, two stops
  task automatic send_char(input logic [7:0] payload, input int bit_len);
    logic [10:0] frame;
    frame = {2'b11, payload, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd_out <= frame[i];
      repeat (bit_len) @(posedge core_clk_in);
    end
  endtask

  // sample each bit near its centre
  task automatic recv_char(input int bit_len, output logic [10:0] frame);
    int n;
    frame = 'x;
    n = 0;
    while (txd_in !== 1'b0 && n < 40 * bit_len)
    begin
      @(posedge core_clk_in);
      n++;
    end
    if (n < 40 * bit_len)
    begin
      repeat (bit_len / 2) @(posedge core_clk_in);
      for (int i = 0; i < 11; i++)
      begin
        frame[i] = txd_in;
        if (i < 10)
          repeat (bit_len) @(posedge core_clk_in);
      end
    end
  endtask
endmodule

// ### serial_control_port.sv
// serial programming port: uart framing, interface select, panel mode control
// Behaviour
// - every frame is exactly eleven bits
// - one start bit, two stop bits always
// - seven data plus parity, or eight data
// - six baud rates, 300 to 9600
// - port active only when locally selected
// - parallel bus disabled while serial selected
// - local command keeps all panel keys working
// - remote command blocks keys except local
// - lockout command blocks every panel key
// - mode commands accepted only via serial port
`timescale 1ns/1ps

module serial_control_port
  import serial_port_pkg::*;
#(
  parameter int KEYS = 8,
  parameter int BIT_CYC_300 = CLK_HZ / BAUD_BASE
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic [KEYS-1:0] panel_keys_in,
  input wire logic local_key_in,
  output logic [KEYS-1:0] panel_keys_out,
  output logic local_key_out,
  output logic gpib_enable_out,
  output logic [1:0] mode_out
);
  localparam int CNT_W = $clog2(BIT_CYC_300 + 1);
  localparam logic [3:0] TX_LAST = 4'(FRAME_BITS - 1);
  localparam logic [3:0] RX_LAST_DATA = 4'(PAYLOAD_BITS - 1);
  localparam logic [3:0] RX_LAST_STOP = 4'(STOP_BITS - 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

  logic ack_reg;
  logic [31:0] dat_reg;
  logic serial_sel_reg;
  logic [1:0] fmt_reg;
  logic [2:0] baud_reg;
  logic [3:0] sticky_reg;
  mode_e mode_reg;
  logic [KEYS-1:0] keys_reg;
  logic local_key_reg;
  logic gpib_en_reg;
  rx_state_e rx_state_reg;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_hold_valid_reg;
  logic [7:0] rx_hold_reg;
  tx_state_e tx_state_reg;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic [3:0] tx_idx_reg;
  logic [FRAME_BITS-1:0] tx_shift_reg;

  // bus decode
  wire req = wb_cyc_in & wb_stb_in & ~ack_reg;
  wire done = wb_cyc_in & wb_stb_in & ack_reg;
  wire wr_lo = done & wb_we_in & wb_sel_in[0];
  wire wr_ctrl = wr_lo & (wb_adr_in == REG_CTRL);
  wire wr_status = wr_lo & (wb_adr_in == REG_STATUS);
  wire wr_tx = wr_lo & (wb_adr_in == REG_TXDATA);
  wire wr_mode = wr_lo & (wb_adr_in == REG_MODECMD);
  wire rd_rx = done & ~wb_we_in & (wb_adr_in == REG_RXDATA);

  // six rates, codes above the top rate clamp to it
  wire [2:0] baud_eff = (baud_reg > BAUD_SEL_MAX) ? BAUD_SEL_MAX : baud_reg;
  wire [CNT_W-1:0] bit_len = CNT_W'(BIT_CYC_300 >> baud_eff);
  wire [CNT_W-1:0] half_len = bit_len >> 1;

  // receive path
  wire rx_tick = (rx_cnt_reg == '0);
  wire rx_done = (rx_state_reg == RX_STOP) & rx_tick & (rx_idx_reg == RX_LAST_STOP);
  wire rx_ferr_evt = (rx_state_reg == RX_STOP) & rx_tick & ~rxd_in;
  wire rx_par_odd = ^rx_shift_reg;
  wire rx_perr_evt = rx_done & (((fmt_reg == FMT_7E) & rx_par_odd) | ((fmt_reg == FMT_7O) & ~rx_par_odd));
  // format code 3 behaves as eight data bits, same as the transmitter
  wire rx_fmt7 = (fmt_reg == FMT_7E) | (fmt_reg == FMT_7O);
  wire [7:0] rx_char = rx_fmt7 ? {1'b0, rx_shift_reg[6:0]} : rx_shift_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire hold_taken = rx_hold_valid_reg & fifo_in_ready;
  wire rx_ovr_evt = rx_done & rx_hold_valid_reg & ~fifo_in_ready;

  // transmit path
  wire tx_ready = (tx_state_reg == TX_IDLE) & serial_sel_reg;
  wire tx_load = wr_tx & tx_ready;
  wire tx_tick = (tx_cnt_reg == '0);
  wire tx_end = (tx_state_reg == TX_SEND) & tx_tick & (tx_idx_reg == TX_LAST);
  wire [6:0] tx_d7 = wb_dat_in[6:0];
  wire [7:0] tx_payload = (fmt_reg == FMT_7E) ? {^tx_d7, tx_d7} :
                          (fmt_reg == FMT_7O) ? {~^tx_d7, tx_d7} : wb_dat_in[7:0];

  // mode commands
  wire [1:0] cmd_code = wb_dat_in[1:0];
  wire cmd_ok = wr_mode & serial_sel_reg & (cmd_code != 2'h3);
  wire cmd_refused = wr_mode & ~cmd_ok;

  wire [3:0] sticky_evt = {cmd_refused, rx_ferr_evt, rx_perr_evt, rx_ovr_evt};
  wire [3:0] sticky_clr = wr_status ? wb_dat_in[ST_STICKY_LSB +: 4] : 4'h0;

  wire [31:0] ctrl_word = {26'h0, baud_reg, fmt_reg, serial_sel_reg};
  wire [31:0] status_word = {24'h0, sticky_reg, fifo_out_valid, tx_ready, mode_reg};
  wire [31:0] rxdata_word = {23'h0, fifo_out_valid, fifo_out_data};
  wire [31:0] rd_mux = (wb_adr_in == REG_CTRL) ? ctrl_word :
                       (wb_adr_in == REG_STATUS) ? status_word :
                       (wb_adr_in == REG_RXDATA) ? rxdata_word :
                       (wb_adr_in == REG_MODECMD) ? {30'h0, mode_reg} : 32'h0;

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;
  assign txd_out = tx_shift_reg[0];
  assign panel_keys_out = keys_reg;
  assign local_key_out = local_key_reg;
  assign gpib_enable_out = gpib_en_reg;
  assign mode_out = mode_reg;

  // one wait state: ack the cycle after the request, drop it after
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= (req & ~wb_we_in) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      serial_sel_reg <= RST_SER;
      fmt_reg <= RST_FMT;
      baud_reg <= RST_BAUD;
      sticky_reg <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        serial_sel_reg <= wb_dat_in[CTRL_SER_BIT];
        fmt_reg <= wb_dat_in[CTRL_FMT_LSB +: 2];
        baud_reg <= wb_dat_in[CTRL_BAUD_LSB +: 3];
      end
      // a new event beats a simultaneous clear
      sticky_reg <= sticky_evt | (sticky_reg & ~sticky_clr);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      mode_reg <= MODE_LOCAL;
      keys_reg <= '0;
      local_key_reg <= 1'b0;
      gpib_en_reg <= 1'b1;
    end
    else
    begin
      gpib_en_reg <= ~serial_sel_reg;
      if (!serial_sel_reg)
      begin
        mode_reg <= MODE_LOCAL;
      end
      else if (cmd_ok)
      begin
        mode_reg <= mode_e'(cmd_code);
      end
      else if ((mode_reg == MODE_REMOTE) && local_key_in)
      begin
        mode_reg <= MODE_LOCAL;
      end
      // keys pass in local; none in lockout
      keys_reg <= (mode_reg == MODE_LOCAL) ? panel_keys_in : '0;
      local_key_reg <= local_key_in & (mode_reg == MODE_LOCAL);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !serial_sel_reg)
    begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 8'h0;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
        begin
          // half a bit to the centre of start
          if (!rxd_in)
          begin
            rx_cnt_reg <= half_len;
            rx_state_reg <= RX_START;
          end
        end
        RX_START:
        begin
          if (!rx_tick)
          begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end
          else if (rxd_in)
          begin
            // glitch, not a start bit
            rx_state_reg <= RX_IDLE;
          end
          else
          begin
            rx_cnt_reg <= bit_len - 1'b1;
            rx_idx_reg <= 4'h0;
            rx_state_reg <= RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (!rx_tick)
          begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end
          else
          begin
            rx_shift_reg <= {rxd_in, rx_shift_reg[7:1]};
            rx_cnt_reg <= bit_len - 1'b1;
            rx_idx_reg <= (rx_idx_reg == RX_LAST_DATA) ? 4'h0 : rx_idx_reg + 1'b1;
            if (rx_idx_reg == RX_LAST_DATA)
            begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (!rx_tick)
          begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end
          else if (rx_done)
          begin
            rx_state_reg <= RX_IDLE;
          end
          else
          begin
            rx_idx_reg <= rx_idx_reg + 1'b1;
            rx_cnt_reg <= bit_len - 1'b1;
          end
        end
        default:
        begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // holding stage stalls until the buffer takes the character
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      rx_hold_valid_reg <= 1'b0;
      rx_hold_reg <= 8'h0;
    end
    else if (rx_done && (!rx_hold_valid_reg || fifo_in_ready))
    begin
      rx_hold_valid_reg <= 1'b1;
      rx_hold_reg <= rx_char;
    end
    else if (hold_taken)
    begin
      rx_hold_valid_reg <= 1'b0;
    end
  end

  char_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_rx_buffer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(rx_hold_valid_reg),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rx_hold_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(rd_rx),
    .out_data_out(fifo_out_data)
  );

  // transmitter held idle unless selected
  // shift register idles at all ones for a mark line; deselect cuts a frame short
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !serial_sel_reg)
    begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_idx_reg <= 4'h0;
      tx_shift_reg <= '1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          if (tx_load)
          begin
            tx_shift_reg <= {2'b11, tx_payload, 1'b0};
            tx_cnt_reg <= bit_len - 1'b1;
            tx_idx_reg <= 4'h0;
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (!tx_tick)
          begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end
          else if (tx_end)
          begin
            tx_state_reg <= TX_IDLE;
          end
          else
          begin
            tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_BITS-1:1]};
            tx_idx_reg <= tx_idx_reg + 1'b1;
            tx_cnt_reg <= bit_len - 1'b1;
          end
        end
        default:
        begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  AST_FRAME_LEN:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tx_state_reg == TX_SEND) && $past(tx_state_reg == TX_SEND) && (tx_idx_reg != $past(tx_idx_reg))
      |-> (tx_idx_reg == $past(tx_idx_reg) + 4'h1) && (tx_idx_reg <= TX_LAST))
    else $error("tx bit index skipped or ran past the frame");

  AST_START_STOP:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tx_state_reg == TX_SEND) |-> (tx_idx_reg == 4'h0) ? !txd_out : ((tx_idx_reg >= 4'h9) ? txd_out : 1'b1))
    else $error("start bit not low or stop bit not high");

  AST_PARITY:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      $rose(tx_state_reg == TX_SEND) && ((fmt_reg == FMT_7E) || (fmt_reg == FMT_7O))
      |-> (^tx_shift_reg[8:1]) == (fmt_reg == FMT_7O))
    else $error("transmitted parity wrong for format");

  AST_BAUD:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (baud_reg >= BAUD_SEL_MAX) |-> bit_len == CNT_W'(BIT_CYC_300 >> 5))
    else $error("bit period not clamped to fastest rate");

  AST_RX_OFF:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      !serial_sel_reg |=> (rx_state_reg == RX_IDLE) && txd_out)
    else $error("serial port active while not selected");

  AST_GPIB_OFF:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      ##1 (gpib_enable_out != $past(serial_sel_reg)))
    else $error("parallel bus enable does not follow selection");

  AST_LOCAL_KEYS:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (mode_reg == MODE_LOCAL) |=> panel_keys_out == $past(panel_keys_in))
    else $error("keys blocked in local mode");

  AST_REMOTE_ESC:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (mode_reg == MODE_REMOTE) && local_key_in && !cmd_ok |=> (mode_reg == MODE_LOCAL) ##1 (panel_keys_out == $past(panel_keys_in)))
    else $error("local key did not leave remote mode");

  AST_LOCKOUT:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      (mode_reg == MODE_LOCKOUT) |=> (panel_keys_out == '0) && !local_key_out)
    else $error("key passed in lockout mode");

  AST_CMD_SERIAL:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_mode && !serial_sel_reg |=> (mode_reg == MODE_LOCAL) && sticky_reg[3])
    else $error("mode command taken without serial selection");
endmodule

// ### serial_control_port_tb.sv
// self-checking testbench for the serial control port
`timescale 1ns/1ps

module serial_control_port_tb
  import serial_port_pkg::*;
;
  localparam int BIT_CYC = 320;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic rxd;
  logic txd;
  logic [7:0] keys_in = 8'h00;
  logic lkey_in = 1'b0;
  logic [7:0] keys_out;
  logic lkey_out;
  logic gpib_en;
  logic [1:0] mode;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] q;
  logic [10:0] fr;
  logic [7:0] pl;
  logic [1:0] fmts [4] = '{FMT_8N, FMT_7E, FMT_7O, 2'h3};
  logic [2:0] sels [4] = '{3'h5, 3'h5, 3'h5, 3'h4};
  logic [7:0] txb [4] = '{8'hA3, 8'h35, 8'h35, 8'h5C};
  logic [7:0] rxb [4] = '{8'h3C, 8'hC5, 8'h81, 8'h7E};

  serial_control_port #(.KEYS(8), .BIT_CYC_300(BIT_CYC)) i_dut (
    .core_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .rxd_in(rxd), .txd_out(txd), .panel_keys_in(keys_in), .local_key_in(lkey_in),
    .panel_keys_out(keys_out), .local_key_out(lkey_out), .gpib_enable_out(gpib_en), .mode_out(mode));

  host_terminal i_host (.core_clk_in(clk), .txd_in(txd), .rxd_out(rxd));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL, q);
    check("ctrl_reset", q, {26'h0, RST_BAUD, RST_FMT, RST_SER});
    check("gpib_reset", 32'(gpib_en), 32'h1);
    rd(5'h14, q);
    check("unmapped", q, 32'h0);
    wr(REG_MODECMD, 32'h1);
    repeat (2) @(posedge clk);
    check("mode_unselected", 32'(mode), 32'h0);
    rd(REG_STATUS, q);
    check("refused_flag", 32'(q[7]), 32'h1);
    wr(REG_STATUS, 32'h80);
    wr(REG_CTRL, 32'h29);
    repeat (2) @(posedge clk);
    check("gpib_off", 32'(gpib_en), 32'h0);
    wr(REG_MODECMD, 32'h1);
    keys_in <= 8'hA5;
    repeat (3) @(posedge clk);
    check("mode_remote", 32'(mode), 32'h1);
    check("keys_remote", 32'(keys_out), 32'h0);
    lkey_in <= 1'b1;
    repeat (3) @(posedge clk);
    check("mode_back_local", 32'(mode), 32'h0);
    check("keys_local", 32'(keys_out), 32'hA5);
    check("lkey_local", 32'(lkey_out), 32'h1);
    lkey_in <= 1'b0;
    wr(REG_MODECMD, 32'h2);
    lkey_in <= 1'b1;
    repeat (3) @(posedge clk);
    check("mode_lockout", 32'(mode), 32'h2);
    check("keys_lockout", 32'(keys_out), 32'h0);
    check("lkey_lockout", 32'(lkey_out), 32'h0);
    lkey_in <= 1'b0;
    wr(REG_MODECMD, 32'h0);
    repeat (2) @(posedge clk);
    check("keys_local2", 32'(keys_out), 32'hA5);
    wr(REG_MODECMD, 32'h3);
    rd(REG_STATUS, q);
    check("mode_code3", 32'(q[1:0]), 32'h0);
    check("code3_refused", 32'(q[7]), 32'h1);
    wr(REG_STATUS, 32'h80);
    wr(REG_MODECMD, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_CTRL, {26'h0, sels[k], fmts[k], 1'b1});
      wr(REG_TXDATA, {24'h0, txb[k]});
      i_host.recv_char(BIT_CYC >> sels[k], fr);
      pl = txb[k];
      if (fmts[k] == FMT_7E)
        pl[7] = ^txb[k][6:0];
      if (fmts[k] == FMT_7O)
        pl[7] = ~^txb[k][6:0];
      check("tx_frame", 32'(fr), 32'({2'b11, pl, 1'b0}));
      repeat (BIT_CYC >> sels[k]) @(posedge clk);
    end
    wr(REG_CTRL, {26'h0, 3'h5, FMT_8N, 1'b1});
    // hold plus two-entry buffer keep three, the fourth overruns
    for (int k = 0; k < 4; k++)
      i_host.send_char(rxb[k], BIT_CYC >> 5);
    repeat (20) @(posedge clk);
    rd(REG_STATUS, q);
    check("rx_avail", 32'(q[3]), 32'h1);
    check("rx_overrun", 32'(q[4]), 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      rd(REG_RXDATA, q);
      check("rx_char", q, {23'h0, 1'b1, rxb[k]});
    end
    rd(REG_RXDATA, q);
    check("rx_empty", 32'(q[8]), 32'h0);
    wr(REG_STATUS, 32'hF0);
    wr(REG_CTRL, {26'h0, 3'h5, FMT_7E, 1'b1});
    i_host.send_char({^rxb[3][6:0], rxb[3][6:0]}, BIT_CYC >> 5);
    repeat (20) @(posedge clk);
    rd(REG_RXDATA, q);
    check("rx_7e", q, {23'h0, 2'b10, rxb[3][6:0]});
    rd(REG_STATUS, q);
    check("rx_no_errors", 32'(q[7:4]), 32'h0);
    // even-parity character under odd format: flagged, character kept
    wr(REG_CTRL, {26'h0, 3'h5, FMT_7O, 1'b1});
    i_host.send_char({^rxb[3][6:0], rxb[3][6:0]}, BIT_CYC >> 5);
    repeat (20) @(posedge clk);
    rd(REG_STATUS, q);
    check("rx_parity_err", 32'(q[5]), 32'h1);
    rd(REG_RXDATA, q);
    check("rx_7o_kept", q, {23'h0, 2'b10, rxb[3][6:0]});
    wr(REG_CTRL, 32'h28);
    repeat (2) @(posedge clk);
    check("gpib_back", 32'(gpib_en), 32'h1);
    check("mode_deselect", 32'(mode), 32'h0);
    // deselected port neither receives nor transmits
    i_host.send_char(rxb[0], BIT_CYC >> 5);
    wr(REG_TXDATA, 32'h55);
    repeat (20) @(posedge clk);
    check("tx_off", 32'(txd), 32'h1);
    rd(REG_RXDATA, q);
    check("rx_off", 32'(q[8]), 32'h0);
    tally_and_finish();
  end
endmodule

// ### serial_port_pkg.sv
// constants for the serial control port and its two-entry receive buffer
package serial_port_pkg;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_TXDATA = 5'h08;
  localparam logic [4:0] REG_RXDATA = 5'h0C;
  localparam logic [4:0] REG_MODECMD = 5'h10;
  // control fields
  localparam int CTRL_SER_BIT = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int CTRL_BAUD_LSB = 3;
  // status fields, and the valid bit of the receive data word
  localparam int ST_MODE_LSB = 0;
  localparam int ST_TXRDY_BIT = 2;
  localparam int ST_RXAV_BIT = 3;
  localparam int ST_STICKY_LSB = 4;
  localparam int RXD_VALID_BIT = 8;
  // reset values
  localparam logic RST_SER = 1'b0;
  localparam logic [1:0] RST_FMT = 2'h0;
  localparam logic [2:0] RST_BAUD = 3'h5;
  // character formats
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_7E = 2'h1;
  localparam logic [1:0] FMT_7O = 2'h2;
  // framing, timing and panel modes
  localparam int FRAME_BITS = 11;
  localparam int PAYLOAD_BITS = 8;
  localparam int STOP_BITS = 2;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_BASE = 300;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h5;
  typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_LOCKOUT} mode_e;
endpackage

`timescale 1ns/1ps

// small fifo with valid/ready on both sides
module char_buffer
  import serial_port_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;

  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  assign in_ready_out = (count_reg != FULL_CNT);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk_in)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
